// ===== core/tsm_tap.v
// Purpose: Boundary-scan test access port controller with instruction, bypass,
//          identification and boundary scan registers.
// Assumes: Test clock, mode select and data input are pins sampled by clk,
//          which runs well above the test clock rate.
// Notes:   Edges of the test clock are found from its filtered level, so all
//          register actions happen a few clk cycles after the pin edge.
`timescale 1ns/1ps
`include "tsm_consts.vh"

module tsm_tap #(
  // Identification value; arbitrary, bit 0 must stay one.
  parameter [`TSM_ID_LEN-1:0] ID_VALUE = 32'h0000_0001
) (
  // System clock and reset.
  input  wire                     clk,
  input  wire                     rst,
  // Test port pins.
  input  wire                     tck,
  input  wire                     tms,
  input  wire                     tdi,
  output reg                      tdo,
  output reg                      tdo_oe,
  // Boundary chain parallel side.
  input  wire [`TSM_BSR_LEN-1:0]  bsr_pin_in,
  output reg  [`TSM_BSR_LEN-1:0]  bsr_par_out,
  output wire                     test_mode,
  // Controller status.
  output reg  [`TSM_NSTATE-1:0]   tap_state,
  output reg  [`TSM_IR_W-1:0]     cur_instr
);

  // One-hot controller states.
  localparam [15:0] ST_TLR  = 16'h0001;
  localparam [15:0] ST_IDLE = 16'h0002;
  localparam [15:0] ST_SDR  = 16'h0004;
  localparam [15:0] ST_CDR  = 16'h0008;
  localparam [15:0] ST_SHDR = 16'h0010;
  localparam [15:0] ST_E1DR = 16'h0020;
  localparam [15:0] ST_PDR  = 16'h0040;
  localparam [15:0] ST_E2DR = 16'h0080;
  localparam [15:0] ST_UDR  = 16'h0100;
  localparam [15:0] ST_SIR  = 16'h0200;
  localparam [15:0] ST_CIR  = 16'h0400;
  localparam [15:0] ST_SHIR = 16'h0800;
  localparam [15:0] ST_E1IR = 16'h1000;
  localparam [15:0] ST_PIR  = 16'h2000;
  localparam [15:0] ST_E2IR = 16'h4000;
  localparam [15:0] ST_UIR  = 16'h8000;

  // Next state of the controller for one rising test clock edge.
  function [15:0] tsm_next;
    input [15:0] st;
    input        m;
    begin
      // Each state names both exits, so a missing arc stands out at a glance.
      case (st)
        ST_TLR: begin
          if (m) begin
            tsm_next = ST_TLR;
          end else begin
            tsm_next = ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (m) begin
            tsm_next = ST_SDR;
          end else begin
            tsm_next = ST_IDLE;
          end
        end
        ST_SDR: begin
          if (m) begin
            tsm_next = ST_SIR;
          end else begin
            tsm_next = ST_CDR;
          end
        end
        ST_CDR: begin
          if (m) begin
            tsm_next = ST_E1DR;
          end else begin
            tsm_next = ST_SHDR;
          end
        end
        ST_SHDR: begin
          if (m) begin
            tsm_next = ST_E1DR;
          end else begin
            tsm_next = ST_SHDR;
          end
        end
        ST_E1DR: begin
          if (m) begin
            tsm_next = ST_UDR;
          end else begin
            tsm_next = ST_PDR;
          end
        end
        ST_PDR: begin
          if (m) begin
            tsm_next = ST_E2DR;
          end else begin
            tsm_next = ST_PDR;
          end
        end
        ST_E2DR: begin
          if (m) begin
            tsm_next = ST_UDR;
          end else begin
            tsm_next = ST_SHDR;
          end
        end
        ST_UDR: begin
          if (m) begin
            tsm_next = ST_SDR;
          end else begin
            tsm_next = ST_IDLE;
          end
        end
        ST_SIR: begin
          if (m) begin
            tsm_next = ST_TLR;
          end else begin
            tsm_next = ST_CIR;
          end
        end
        ST_CIR: begin
          if (m) begin
            tsm_next = ST_E1IR;
          end else begin
            tsm_next = ST_SHIR;
          end
        end
        ST_SHIR: begin
          if (m) begin
            tsm_next = ST_E1IR;
          end else begin
            tsm_next = ST_SHIR;
          end
        end
        ST_E1IR: begin
          if (m) begin
            tsm_next = ST_UIR;
          end else begin
            tsm_next = ST_PIR;
          end
        end
        ST_PIR: begin
          if (m) begin
            tsm_next = ST_E2IR;
          end else begin
            tsm_next = ST_PIR;
          end
        end
        ST_E2IR: begin
          if (m) begin
            tsm_next = ST_UIR;
          end else begin
            tsm_next = ST_SHIR;
          end
        end
        ST_UIR: begin
          if (m) begin
            tsm_next = ST_SDR;
          end else begin
            tsm_next = ST_IDLE;
          end
        end
        // A corrupted code falls back to reset rather than lock up.
        default: begin
          tsm_next = ST_TLR;
        end
      endcase
    end
  endfunction

  // Data register chosen by an instruction; unknown codes get bypass.
  function [1:0] tsm_sel;
    input [`TSM_IR_W-1:0] ins;
    begin
      case (ins)
        `TSM_IR_EXTEST: tsm_sel = `TSM_SEL_BSR;
        `TSM_IR_SAMPLE: tsm_sel = `TSM_SEL_BSR;
        `TSM_IR_IDCODE: tsm_sel = `TSM_SEL_ID;
        default:        tsm_sel = `TSM_SEL_BYP;
      endcase
    end
  endfunction

  // Pin synchronisers: three stages, stage one feeds only stage two.
  reg  [2:0] sync1;
  reg  [2:0] sync2;
  reg  [2:0] sync3;
  reg  [2:0] filt;
  reg        tck_prev;
  wire [2:0] pin_in;
  wire       tck_f;
  wire       tms_f;
  wire       tdi_f;
  wire       tck_rise;
  wire       tck_fall;

  assign pin_in = {tdi, tms, tck};

  // A level counts once the second and third stages agree.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          sync1[gi] <= 1'h0;
          sync2[gi] <= 1'h0;
          sync3[gi] <= 1'h0;
          filt[gi]  <= 1'h0;
        end else begin
          sync1[gi] <= pin_in[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            filt[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate

  assign tck_f = filt[0];
  assign tms_f = filt[1];
  assign tdi_f = filt[2];

  // Edge detection on the filtered test clock.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tck_prev <= 1'h0;
    end else begin
      tck_prev <= tck_f;
    end
  end

  assign tck_rise = tck_f & ~tck_prev;
  assign tck_fall = ~tck_f & tck_prev;

  // Controller state; reset lands in test-logic-reset.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tap_state <= ST_TLR;
    end else if (tck_rise) begin
      tap_state <= tsm_next(tap_state, tms_f);
    end
  end

  // Shift registers of the instruction and data paths.
  reg  [`TSM_IR_W-1:0]    ir_sh;
  reg  [`TSM_BSR_LEN-1:0] bsr_sh;
  reg  [`TSM_ID_LEN-1:0]  id_sh;
  reg                     byp;
  wire [1:0]              sel;

  assign sel = tsm_sel(cur_instr);

  // Instruction shifter: fixed capture, LSB nearest TDO.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ir_sh <= `TSM_IR_CAPTURE;
    end else if (tck_rise) begin
      if (tap_state == ST_CIR) begin
        ir_sh <= `TSM_IR_CAPTURE;
      end else if (tap_state == ST_SHIR) begin
        ir_sh <= {tdi_f, ir_sh[`TSM_IR_W-1:1]};
      end
    end
  end

  // Data shifters; only the selected one moves, the rest hold.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      bsr_sh <= {`TSM_BSR_LEN{1'h0}};
      id_sh  <= {`TSM_ID_LEN{1'h0}};
      byp    <= `TSM_BYP_CAPTURE;
    end else if (tck_rise) begin
      if (tap_state == ST_CDR) begin
        case (sel)
          `TSM_SEL_BSR: bsr_sh <= bsr_pin_in;
          `TSM_SEL_ID:  id_sh  <= ID_VALUE;
          default:      byp    <= `TSM_BYP_CAPTURE;
        endcase
      end else if (tap_state == ST_SHDR) begin
        case (sel)
          `TSM_SEL_BSR: bsr_sh <= {tdi_f, bsr_sh[`TSM_BSR_LEN-1:1]};
          `TSM_SEL_ID:  id_sh  <= {tdi_f, id_sh[`TSM_ID_LEN-1:1]};
          default:      byp    <= tdi_f;
        endcase
      end
      // Every other state leaves the shifters alone.
    end
  end

  // Current instruction for the next clk; the reset state wins over an update.
  reg [`TSM_IR_W-1:0] next_instr;
  reg                 ext_mode;

  always @* begin
    next_instr = cur_instr;
    if (tap_state == ST_TLR) begin
      next_instr = `TSM_IR_IDCODE;
    end else if (tck_fall && tap_state == ST_UIR) begin
      next_instr = ir_sh;
    end
  end

  // Falling-edge updates: boundary latch, current instruction and test mode.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      bsr_par_out <= {`TSM_BSR_LEN{1'h0}};
      cur_instr   <= `TSM_IR_IDCODE;
      ext_mode    <= 1'h0;
    end else begin
      cur_instr <= next_instr;
      // Taken from the next instruction, so the mode never lags cur_instr.
      ext_mode  <= (next_instr == `TSM_IR_EXTEST);
      if (tck_fall && tap_state == ST_UDR && sel == `TSM_SEL_BSR) begin
        bsr_par_out <= bsr_sh;
      end
    end
  end

  // Pins follow the latch only under external test; sample keeps the normal path.
  assign test_mode = ext_mode;

  // Serial output: changes on the falling edge, driven in shift states.
  reg next_tdo;

  always @* begin
    next_tdo = ir_sh[0];
    if (tap_state == ST_SHDR) begin
      case (sel)
        `TSM_SEL_BSR: next_tdo = bsr_sh[0];
        `TSM_SEL_ID:  next_tdo = id_sh[0];
        default:      next_tdo = byp;
      endcase
    end
  end

  // Enable drops on the first falling edge after the state leaves shifting, so no stray drive.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tdo    <= 1'h0;
      tdo_oe <= 1'h0;
    end else if (tck_fall) begin
      tdo    <= next_tdo;
      tdo_oe <= (tap_state == ST_SHDR) || (tap_state == ST_SHIR);
    end
  end

endmodule // tsm_tap

// ===== core/tsm_consts.vh
// Purpose: Constants for the test access port controller.
// Assumes: Included by its bare name from the core design file.
// Notes:   Definitions only.
`ifndef TSM_CONSTS_VH
`define TSM_CONSTS_VH

// Instruction register width and codes.
`define TSM_IR_W        3
`define TSM_IR_EXTEST   3'h0
`define TSM_IR_SAMPLE   3'h4
`define TSM_IR_IDCODE   3'h6
`define TSM_IR_BYPASS   3'h7
`define TSM_IR_CAPTURE  3'h4

// Data register lengths.
`define TSM_BSR_LEN     98
`define TSM_ID_LEN      32

// Data register select codes.
`define TSM_SEL_BSR     2'h0
`define TSM_SEL_ID      2'h1
`define TSM_SEL_BYP     2'h2

// Value captured into the bypass bit.
`define TSM_BYP_CAPTURE 1'h0

// Number of states.
`define TSM_NSTATE      16

`endif

// ===== bench/tsm_tester.sv
// Purpose: Model of the external boundary-scan tester.
// Assumes: Steps are started at falling clk edges.
// Notes:   One step is one test clock period of eight clk cycles.
`timescale 1ns/1ps
module tsm_tester (
  // Sampling clock.
  input  wire clk,
  // Test port pins.
  output reg  tck,
  output reg  tms,
  output reg  tdi,
  input  wire tdo,
  input  wire tdo_oe
);
  reg seen;
  // The clock starts low, since a high level at reset release reads as an edge.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    seen = 1'b0;
  end
  // TDO is read late in the high half, long after the falling edge launched it.
  // An undriven TDO reads as unknown, so an idle driver never passes a check.
  task step(input m, input d);
    tck = 1'b0;
    tms = m;
    tdi = d;
    repeat (4) @(negedge clk);
    tck = 1'b1;
    repeat (4) @(negedge clk);
    seen = tdo_oe ? tdo : 1'bx;
  endtask
endmodule // tsm_tester

// ===== bench/tsm_tap_chk.sv
// Purpose: Port checker for the test access port controller.
// Assumes: Sees only top-level ports of tsm_tap.
// Notes:   State bits follow the one-hot order of tap_state.
`timescale 1ns/1ps
`include "tsm_consts.vh"
module tsm_tap_chk (
  // Clock and reset.
  input wire                    clk,
  input wire                    rst,
  // Watched outputs.
  input wire                    tdo_oe,
  input wire [`TSM_BSR_LEN-1:0] bsr_par_out,
  input wire                    test_mode,
  input wire [`TSM_NSTATE-1:0]  tap_state,
  input wire [`TSM_IR_W-1:0]    cur_instr
);
  // Every check runs on the system clock and sleeps through reset.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_tlr_ir; tap_state[0] |=> cur_instr == `TSM_IR_IDCODE; endproperty
  a_tlr_ir: assert property (p_tlr_ir) else $error("ident not current");
  property p_tlr_mode; tap_state[0] |=> !test_mode; endproperty
  a_tlr_mode: assert property (p_tlr_mode) else $error("test mode in reset");
  property p_par; !$stable(bsr_par_out) |-> tap_state[8]; endproperty
  a_par: assert property (p_par) else $error("latch moved");
  property p_instr; !$stable(cur_instr) |-> tap_state[15] || tap_state[0]; endproperty
  a_instr: assert property (p_instr) else $error("instr moved");
  property p_oe_on; $rose(tdo_oe) |-> tap_state[4] || tap_state[11]; endproperty
  a_oe_on: assert property (p_oe_on) else $error("tdo on");
  property p_oe_off; $fell(tdo_oe) |-> !(tap_state[4] || tap_state[11]); endproperty
  a_oe_off: assert property (p_oe_off) else $error("tdo off");
  property p_seldr; $fell(tap_state[2]) |-> tap_state[3] || tap_state[9]; endproperty
  a_seldr: assert property (p_seldr) else $error("sel dr exit");
  property p_selir; $fell(tap_state[9]) |-> tap_state[10] || tap_state[0]; endproperty
  a_selir: assert property (p_selir) else $error("sel ir exit");
  property p_ex1dr; $fell(tap_state[5]) |-> tap_state[8] || tap_state[6]; endproperty
  a_ex1dr: assert property (p_ex1dr) else $error("exit1 dr exit");
  property p_upd; $fell(tap_state[15]) |-> tap_state[1] || tap_state[2]; endproperty
  a_upd: assert property (p_upd) else $error("update ir exit");
endmodule // tsm_tap_chk
bind tsm_tap tsm_tap_chk tsm_tap_chk_i (.clk(clk), .rst(rst), .tdo_oe(tdo_oe),
  .bsr_par_out(bsr_par_out), .test_mode(test_mode), .tap_state(tap_state),
  .cur_instr(cur_instr));

// ===== bench/tap_state_machine_tb.sv
// Purpose: Self-checking bench for the test access port controller.
// Assumes: Inputs change at falling clk edges only.
// Notes:   Test clock period is 160 ns; no random values.
`timescale 1ns/1ps
`include "tsm_consts.vh"
module tap_state_machine_tb;
  localparam [31:0] ID = 32'h5A3C_0E21; // Arbitrary value, bit 0 set.
  reg                    clk;
  reg                    rst;
  reg [`TSM_BSR_LEN-1:0] pins;
  reg [`TSM_BSR_LEN-1:0] d;
  wire                   tck, tms, tdi, tdo, tdo_oe, test_mode;
  wire [`TSM_BSR_LEN-1:0] par;
  wire [15:0]            st;
  wire [2:0]             ir;
  integer                err_total, n_tests, cyc, k;
  tsm_tap #(.ID_VALUE(ID)) tsm_tap_i (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .bsr_pin_in(pins), .bsr_par_out(par),
    .test_mode(test_mode), .tap_state(st), .cur_instr(ir));
  tsm_tester tsm_tester_i (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe));
  // Clock, and a ceiling well above the about 3030 cycles the run needs.
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      tally_and_finish;
    end
  end
  task chk(input string nm, input [97:0] e, input [97:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("[ERR] %0s exp %h got %h", nm, e, g);
    end
  endtask
  task s(input m);
    tsm_tester_i.step(m, 1'b0);
  endtask
  // State moves a few clk after the rising edge, so wait before looking.
  task cs(input [15:0] e);
    repeat (2) @(negedge clk);
    chk("state", e, st);
  endtask
  // From idle, scan n bits of one path; pz detours through the pause state.
  task scan(input irp, input integer n, input [97:0] din, input pz);
    integer i;
    s(1);
    if (irp) s(1);
    s(0);
    s(0);
    d = '0;
    for (i = 0; i < n; i = i + 1) begin
      tsm_tester_i.step(i == n - 1, din[i]);
      d[i] = tsm_tester_i.seen;
    end
    if (pz) begin
      s(0);
      s(0);
      s(1);
    end
    s(1);
    s(0);
  endtask
  task load_ir(input [2:0] c);
    scan(1'b1, 3, {95'h0, c}, 1'b0);
    chk("capir", 98'h4, d);
    chk("instr", c, ir);
  endtask
  task t_reset;
    chk("state", 16'h0001, st);
    chk("instr", 3'h6, ir);
    chk("mode", 1'b0, test_mode);
    s(1);
    s(1);
    cs(16'h0001);
    s(0);
    cs(16'h0002);
  endtask
  task t_instr;
    for (k = 0; k < 4; k = k + 1) begin
      load_ir(12'hFA0 >> (3 * k));
      chk("mode", k == 0, test_mode);
    end
  endtask
  task t_bypass;
    load_ir(3'h7);
    scan(1'b0, 8, 98'hB5, 1'b0);
    chk("bypass", 98'h6A, d);
  endtask
  task t_ident;
    load_ir(3'h6);
    scan(1'b0, 32, 98'h0, 1'b0);
    chk("ident", ID, d);
  endtask
  task t_bsr;
    for (k = 0; k < 2; k = k + 1) begin
      pins = {2'h2, 32'hC3A5_0F1E, 32'h1E0F_A5C3, 32'h9617_4D28} ^ {98{k[0]}};
      load_ir(k ? 3'h4 : 3'h0);
      scan(1'b0, 98, {pins[48:0], pins[97:49]}, 1'b1);
      chk("capdr", pins, d);
      chk("latch", {pins[48:0], pins[97:49]}, par);
    end
  endtask
  // Leave mid-shift with TMS high; five edges must reach reset.
  task t_force;
    load_ir(3'h7);
    s(1);
    s(0);
    s(0);
    repeat (5) s(1);
    cs(16'h0001);
    chk("instr", 3'h6, ir);
  endtask
  // Walk the arcs the scans never take: early exits, the IR pause, exit2 returns.
  task t_paths;
    s(0);
    s(0);
    cs(16'h0002);
    s(1);
    s(0);
    s(1);
    cs(16'h0020);
    s(0);
    cs(16'h0040);
    s(1);
    s(0);
    cs(16'h0010);
    s(1);
    s(1);
    s(1);
    cs(16'h0004);
    s(1);
    s(0);
    s(1);
    cs(16'h1000);
    s(0);
    s(0);
    cs(16'h2000);
    chk("tdo_oe", 1'b0, tdo_oe);
    s(1);
    s(0);
    cs(16'h0800);
    s(1);
    s(1);
    s(0);
    cs(16'h0002);
    chk("instr", 3'h2, ir);
    chk("mode", 1'b0, test_mode);
  endtask
  task tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Reset for ten cycles, then run every scenario.
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    pins = '0;
    err_total = 0;
    n_tests = 0;
    cyc = 0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset;
    t_instr;
    t_bypass;
    t_ident;
    t_bsr;
    t_force;
    t_paths;
    tally_and_finish;
  end
endmodule // tap_state_machine_tb
